// file: verilog/fcsr_pkg.sv
package fcsr_pkg;
	localparam int ADDR_W = 20;
	localparam int DATA_W = 16;
	localparam int CNT_W = 12;
	// Bus timing in ns (suspend limit in us), converted to clk_in cycles (round up)
	localparam int CLK_PERIOD_NS = 50;
	localparam int T_WE_LOW_NS = 45;
	localparam int T_WE_HIGH_NS = 30;
	localparam int T_READ_ACC_NS = 70;
	localparam int T_SUSP_MAX_US = 25;
	localparam int SYNC_STAGES = 2;
	localparam int WE_CYC = (T_WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WH_CYC = (T_WE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RD_CYC = (T_READ_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES;
	localparam int SUSP_CYC = (T_SUSP_MAX_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Command words
	localparam logic [7:0] D_UNLK1 = 8'haa;
	localparam logic [7:0] D_UNLK2 = 8'h55;
	localparam logic [7:0] D_RESET = 8'hf0;
	localparam logic [7:0] D_AUTOSEL = 8'h90;
	localparam logic [7:0] D_PROG = 8'ha0;
	localparam logic [7:0] D_BYPASS = 8'h20;
	localparam logic [7:0] D_BYP_EXIT2 = 8'h00;
	localparam logic [7:0] D_ERASE_SETUP = 8'h80;
	localparam logic [7:0] D_CHIP_ERASE = 8'h10;
	localparam logic [7:0] D_BLK_ERASE = 8'h30;
	localparam logic [7:0] D_SUSPEND = 8'hb0;
	localparam logic [7:0] D_RESUME = 8'h30;
	localparam logic [7:0] D_QUERY = 8'h98;
	// Word addresses; byte mode adds the low select bit below
	localparam logic [10:0] A_CMD = 11'h555;
	localparam logic [10:0] A_UNLK2 = 11'h2aa;
	localparam logic [10:0] A_QUERY = 11'h055;
	localparam int BLK_SHIFT = 15;
	typedef enum logic [3:0] {
		OP_READ, OP_RESET, OP_AUTOSEL, OP_PROG, OP_BYP_ENTER, OP_BYP_PROG, OP_BYP_EXIT,
		OP_CHIP_ERASE, OP_BLK_ERASE, OP_BLK_ADD, OP_SUSPEND, OP_RESUME, OP_QUERY
	} fcsr_op_e;
	typedef enum logic [2:0] {
		MD_ARRAY, MD_IDENT, MD_QRY_ARR, MD_QRY_IDENT, MD_BYPASS, MD_BUSY_PROG,
		MD_BUSY_CHIP, MD_BUSY_BLK
	} fcsr_mode_e;
	typedef enum logic [2:0] {ST_IDLE, ST_WR_LO, ST_WR_HI, ST_RD, ST_LAT} fcsr_st_e;
	typedef struct packed {
		fcsr_op_e op;
		logic [ADDR_W-1:0] addr;
		logic alsb;
		logic [DATA_W-1:0] data;
	} fcsr_req_s;
	typedef struct packed {
		logic [ADDR_W-1:0] a;
		logic lsb;
		logic [DATA_W-1:0] d;
	} fcsr_bus_s;
	typedef struct packed {
		fcsr_st_e st;
		fcsr_mode_e md;
		fcsr_req_s req;
		logic [2:0] idx;
		logic [CNT_W-1:0] cnt;
		logic susp;
		logic clean;
		logic open;
		logic byp_ret;
		logic [ADDR_W-BLK_SHIFT-1:0] blk;
		logic bm;
		logic byte_n;
		logic [DATA_W-1:0] s1;
		logic [DATA_W-1:0] s2;
		fcsr_bus_s bus;
		logic ce_n;
		logic we_n;
		logic oe_n;
		logic dq_oe;
		logic ready;
		logic done;
		logic err;
		logic [DATA_W-1:0] rdata;
	} fcsr_state_s;
endpackage

// file: verilog/fcsr_host.sv
// Notes on behaviour
// RULE1: Suspend is one write of B0.
// RULE2: Device stops erase within 25 us.
// RULE3: Suspend during block timeout is immediate.
// RULE4: No block additions after a resume.
// RULE5: Other blocks read and program normally.
// RULE6: Program to suspended block is dropped.
// RULE7: Reads in erasing block return status.
// RULE8: Ident, query, bypass allowed while suspended.
// RULE9: Resume only after read/reset to array.
// RULE10: Resume is 30; repeatable.
// RULE11: Query is 98, from array or ident.
// RULE12: Query mode reads the query area.
// RULE13: Reset from query returns previous mode.
// RULE14: Unlock AA/55 at fixed addresses.
// RULE15: Only low address and data decoded.
// RULE16: Read/reset is F0 at any address.
// RULE17: Identifier read is unlock then 90.
// RULE18: Program is unlock, A0, target value.
// RULE19: Bypass entry is unlock then 20.
// RULE20: Bypass program A0; exit 90 then 00.
// RULE21: Chip erase is six writes ending 10.
// RULE22: Block erase ends 30; may repeat.
// RULE23: Busy device ignores commands except suspend; the host accepts suspend only during block erase, not program or chip erase.
// RULE24: Suspended status shows polling bit one.
// RULE25: Unexpected write abandons the sequence.
module fcsr_host
	import fcsr_pkg::*;
(
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic en_in,
	input wire logic req_valid_in,
	input wire fcsr_pkg::fcsr_req_s req_in,
	input wire logic byte_mode_in,
	input wire logic op_end_in,
	input wire logic [fcsr_pkg::DATA_W-1:0] dq_in,
	output logic ready_out,
	output logic done_out,
	output logic err_out,
	output logic [fcsr_pkg::DATA_W-1:0] rdata_out,
	output logic suspended_out,
	output fcsr_pkg::fcsr_mode_e mode_out,
	output logic [fcsr_pkg::ADDR_W-1:0] addr_out,
	output logic [fcsr_pkg::DATA_W-1:0] dq_out,
	output logic dq_oe_out,
	output logic ce_n_out,
	output logic we_n_out,
	output logic oe_n_out,
	output logic byte_n_out
);
	import fcsr_pkg::*;
	if (WE_CYC < 1 || WH_CYC < 1 || RD_CYC >= (1 << CNT_W) || SUSP_CYC >= (1 << CNT_W)
		|| ADDR_W <= BLK_SHIFT || DATA_W != 16) begin : g_bad_cfg
		$error("fcsr_host: timing counts or widths do not fit");
	end

	fcsr_state_s r;
	fcsr_state_s n;
	logic ok;
	logic acc;

	function automatic logic [2:0] seq_last(input fcsr_op_e op);
		case (op)
			OP_AUTOSEL, OP_BYP_ENTER: seq_last = 3'h2;
			OP_PROG: seq_last = 3'h3;
			OP_BYP_PROG, OP_BYP_EXIT: seq_last = 3'h1;
			OP_CHIP_ERASE, OP_BLK_ERASE: seq_last = 3'h5;
			default: seq_last = 3'h0;
		endcase
	endfunction

	function automatic fcsr_bus_s cmd(input logic [10:0] a, input logic [7:0] d, input logic bm);
		fcsr_bus_s b;
		b = '0;
		// Byte mode: word address plus low select bit on the shared pin
		b.a = {{(ADDR_W-11){1'b0}}, a};
		b.lsb = bm && (a == A_UNLK2);
		b.d = {8'h00, d};
		return b;
	endfunction

	function automatic fcsr_bus_s step(input fcsr_req_s q, input logic [2:0] i, input logic bm);
		fcsr_bus_s u;
		u = '0;
		u.a = q.addr;
		u.lsb = q.alsb;
		u.d = q.data;
		step = u;
		case (q.op)
			// RULE16: single reset write
			OP_RESET: step = cmd(11'h000, D_RESET, bm);
			// RULE1: single suspend write
			OP_SUSPEND: step = cmd(11'h000, D_SUSPEND, bm);
			// RULE10: single resume write
			OP_RESUME: step = cmd(11'h000, D_RESUME, bm);
			// RULE11: query at its own address
			OP_QUERY: step = cmd(A_QUERY, D_QUERY, bm);
			// RULE20: bypass program and exit
			OP_BYP_PROG: step = (i == 3'h0) ? cmd(11'h000, D_PROG, bm) : u;
			OP_BYP_EXIT: step = cmd(11'h000, (i == 3'h0) ? D_AUTOSEL : D_BYP_EXIT2, bm);
			OP_BLK_ADD: begin
				u.d = {8'h00, D_BLK_ERASE};
				step = u;
			end
			default: begin
				// RULE14: unlock pair opens each long sequence
				if (i == 3'h0 || (i == 3'h3 && q.op != OP_PROG)) begin
					step = cmd(A_CMD, D_UNLK1, bm);
				end else if (i == 3'h1 || i == 3'h4) begin
					step = cmd(A_UNLK2, D_UNLK2, bm);
				end else if (i == 3'h2) begin
					// RULE17: RULE18: RULE19: RULE21: third write code
					case (q.op)
						OP_AUTOSEL: step = cmd(A_CMD, D_AUTOSEL, bm);
						OP_PROG: step = cmd(A_CMD, D_PROG, bm);
						OP_BYP_ENTER: step = cmd(A_CMD, D_BYPASS, bm);
						default: step = cmd(A_CMD, D_ERASE_SETUP, bm);
					endcase
				end else if (q.op == OP_CHIP_ERASE) begin
					step = cmd(A_CMD, D_CHIP_ERASE, bm);
				end else if (q.op == OP_BLK_ERASE) begin
					// RULE22: block address with 30
					u.d = {8'h00, D_BLK_ERASE};
					step = u;
				end
			end
		endcase
		// RULE15: select bit on top pin
		if (bm) begin
			step.d = {step.lsb, {(DATA_W-9){1'b0}}, step.d[7:0]};
		end
	endfunction

	// Which requests the device will honour in its present mode
	always_comb begin
		ok = 1'b0;
		case (r.md)
			MD_ARRAY: begin
				case (req_in.op)
					OP_READ, OP_RESET, OP_AUTOSEL, OP_BYP_ENTER, OP_QUERY: ok = 1'b1;
					// RULE6: never program the suspended block from array mode
					OP_PROG: ok = !(r.susp && req_in.addr[ADDR_W-1:BLK_SHIFT] == r.blk);
					OP_CHIP_ERASE, OP_BLK_ERASE: ok = !r.susp;
					// RULE9: resume waits for a reset to array
					OP_RESUME: ok = r.susp && r.clean;
					default: ok = 1'b0;
				endcase
			end
			// RULE11: query from ident mode too
			MD_IDENT: ok = req_in.op inside {OP_READ, OP_RESET, OP_QUERY};
			MD_QRY_ARR, MD_QRY_IDENT: ok = req_in.op inside {OP_READ, OP_RESET};
			MD_BYPASS: ok = req_in.op inside {OP_READ, OP_BYP_PROG, OP_BYP_EXIT};
			// RULE23: only suspend, reads and additions while erasing blocks
			MD_BUSY_BLK: begin
				ok = req_in.op inside {OP_READ, OP_SUSPEND} || (req_in.op == OP_BLK_ADD && r.open);
			end
			default: ok = (req_in.op == OP_READ);
		endcase
	end

	assign acc = en_in && r.st == ST_IDLE && req_valid_in && ok;

	always_comb begin
		n = r;
		n.done = 1'b0;
		n.err = 1'b0;
		n.s1 = dq_in;
		n.s2 = r.s1;
		case (r.st)
			ST_IDLE: begin
				if (req_valid_in && !ok) begin
					// RULE25: refused request leaves the mode as is
					n.err = 1'b1;
				end else if (acc) begin
					n.req = req_in;
					n.bm = byte_mode_in;
					n.byte_n = !byte_mode_in;
					n.idx = '0;
					n.cnt = '0;
					n.ce_n = 1'b0;
					n.bus.a = req_in.addr;
					n.bus.lsb = req_in.alsb;
					if (req_in.op == OP_READ) begin
						n.st = ST_RD;
						n.oe_n = 1'b0;
					end else begin
						n.st = ST_WR_LO;
						n.we_n = 1'b0;
						n.dq_oe = 1'b1;
						n.bus = step(req_in, 3'h0, byte_mode_in);
					end
				end
			end
			ST_WR_LO: begin
				n.cnt = r.cnt + 1'b1;
				if (r.cnt == CNT_W'(WE_CYC - 1)) begin
					n.we_n = 1'b1;
					n.cnt = '0;
					n.st = ST_WR_HI;
				end
			end
			ST_WR_HI: begin
				n.cnt = r.cnt + 1'b1;
				if (r.cnt == CNT_W'(WH_CYC - 1)) begin
					n.cnt = '0;
					if (r.idx != seq_last(r.req.op)) begin
						n.idx = r.idx + 1'b1;
						n.st = ST_WR_LO;
						n.we_n = 1'b0;
						n.bus = step(r.req, r.idx + 3'h1, r.bm);
					end else begin
						n.dq_oe = 1'b0;
						n.ce_n = 1'b1;
						n.st = ST_IDLE;
						n.done = 1'b1;
						n.clean = 1'b0;
						case (r.req.op)
							OP_RESET: begin
								// RULE13: query returns to the mode it came from
								n.md = (r.md == MD_QRY_IDENT) ? MD_IDENT : MD_ARRAY;
								n.clean = (r.md == MD_ARRAY) || (r.md == MD_QRY_ARR);
							end
							OP_AUTOSEL: n.md = MD_IDENT;
							// RULE12: query reads until reset
							OP_QUERY: n.md = (r.md == MD_IDENT) ? MD_QRY_IDENT : MD_QRY_ARR;
							// RULE8: bypass may be entered while suspended
							OP_BYP_ENTER: n.md = MD_BYPASS;
							OP_BYP_EXIT: n.md = MD_ARRAY;
							OP_PROG, OP_BYP_PROG: begin
								n.md = MD_BUSY_PROG;
								n.byp_ret = (r.req.op == OP_BYP_PROG);
							end
							OP_CHIP_ERASE: n.md = MD_BUSY_CHIP;
							OP_BLK_ERASE: begin
								n.md = MD_BUSY_BLK;
								n.open = 1'b1;
								n.blk = r.req.addr[ADDR_W-1:BLK_SHIFT];
							end
							OP_BLK_ADD: n.blk = r.req.addr[ADDR_W-1:BLK_SHIFT];
							OP_SUSPEND: begin
								// RULE3: additions end at suspend
								n.open = 1'b0;
								n.susp = 1'b1;
								n.done = 1'b0;
								n.ce_n = 1'b0;
								n.st = ST_LAT;
							end
							OP_RESUME: begin
								// RULE10: back to erasing; RULE4: list stays closed
								n.md = MD_BUSY_BLK;
								n.susp = 1'b0;
							end
							default: n.md = r.md;
						endcase
					end
				end
			end
			ST_LAT: begin
				// RULE2: wait out the worst suspend latency
				n.cnt = r.cnt + 1'b1;
				if (r.cnt == CNT_W'(SUSP_CYC - 1)) begin
					n.cnt = '0;
					n.md = MD_ARRAY;
					n.ce_n = 1'b1;
					n.st = ST_IDLE;
					n.done = 1'b1;
				end
			end
			default: begin
				// RULE7: data may be status in an erasing block
				n.cnt = r.cnt + 1'b1;
				if (r.cnt == CNT_W'(RD_CYC - 1)) begin
					n.rdata = r.s2;
					n.oe_n = 1'b1;
					n.ce_n = 1'b1;
					n.cnt = '0;
					n.st = ST_IDLE;
					n.done = 1'b1;
				end
			end
		endcase
		if (op_end_in && r.md inside {MD_BUSY_PROG, MD_BUSY_CHIP, MD_BUSY_BLK}) begin
			n.md = r.byp_ret ? MD_BYPASS : MD_ARRAY;
			n.byp_ret = 1'b0;
			n.open = 1'b0;
			if (r.md != MD_BUSY_PROG) begin
				n.susp = 1'b0;
			end
		end
		n.ready = (n.st == ST_IDLE);
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			r <= '0;
			r.st <= ST_IDLE;
			r.md <= MD_ARRAY;
			r.ce_n <= 1'b1;
			r.we_n <= 1'b1;
			r.oe_n <= 1'b1;
			r.ready <= 1'b1;
			r.byte_n <= 1'b1;
		end else if (en_in) begin
			r <= n;
		end
	end

	assign ready_out = r.ready;
	assign done_out = r.done;
	assign err_out = r.err;
	assign rdata_out = r.rdata;
	assign suspended_out = r.susp;
	assign mode_out = r.md;
	assign addr_out = r.bus.a;
	assign dq_out = r.bus.d;
	assign dq_oe_out = r.dq_oe;
	assign ce_n_out = r.ce_n;
	assign we_n_out = r.we_n;
	assign oe_n_out = r.oe_n;
	assign byte_n_out = r.byte_n;

	we_oe_excl_a: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RULE18
		!(!r.we_n && !r.oe_n)) else $error("write and read strobes overlap");
	resume_gate_a: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RULE9
		acc && req_in.op == OP_RESUME |-> r.md == MD_ARRAY && r.susp && r.clean)
		else $error("resume issued without prior reset");
	query_gate_a: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RULE11
		acc && req_in.op == OP_QUERY |-> r.md inside {MD_ARRAY, MD_IDENT})
		else $error("query issued from wrong mode");
	blk_add_a: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RULE4
		acc && req_in.op == OP_BLK_ADD |-> r.open && !r.susp)
		else $error("block added after resume");
	susp_prog_a: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RULE6
		acc && req_in.op == OP_PROG && r.susp |-> req_in.addr[ADDR_W-1:BLK_SHIFT] != r.blk)
		else $error("program aimed at suspended block");
	busy_gate_a: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RULE23
		acc && r.md inside {MD_BUSY_PROG, MD_BUSY_CHIP} |-> req_in.op == OP_READ)
		else $error("command sent to busy device");
	susp_wait_a: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RULE2
		en_in && r.st == ST_LAT && r.cnt != CNT_W'(SUSP_CYC - 1) |=> r.st == ST_LAT)
		else $error("suspend latency cut short");
	we_width_a: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RULE14
		en_in && r.st == ST_WR_LO && r.cnt != CNT_W'(WE_CYC - 1) |=> !r.we_n)
		else $error("write strobe too short");
	unlock_a: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RULE14
		en_in && r.st == ST_WR_LO && r.idx == 3'h1 && r.req.op == OP_PROG
		|-> r.bus.d[7:0] == D_UNLK2 && r.bus.a[10:0] == A_UNLK2)
		else $error("second unlock write wrong");
	qry_return_a: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RULE13
		en_in && r.md == MD_QRY_IDENT && r.st == ST_WR_HI && r.req.op == OP_RESET
		&& r.cnt == CNT_W'(WH_CYC - 1) |=> r.md == MD_IDENT)
		else $error("reset from query lost ident mode");
endmodule

// file: testbench/fcsr_flash_model.sv
module fcsr_flash_model
	import fcsr_pkg::*;
#(
	// Identity value is arbitrary
	parameter logic [15:0] ID_CODE = 16'h1a2b
)
(
	input wire logic ce_n_in,
	input wire logic we_n_in,
	input wire logic oe_n_in,
	input wire logic byte_n_in,
	input wire logic op_end_in,
	input wire logic [19:0] addr_in,
	input wire logic [15:0] dq_in,
	output logic [15:0] dq_out
);
	timeunit 1ns;
	timeprecision 1ns;
	fcsr_mode_e mode = MD_ARRAY;
	logic susp = 1'b0;
	logic list_open = 1'b0;
	logic byp = 1'b0;
	logic rst_ok = 1'b0;
	logic [3:0] step = 4'h0;
	logic [4:0] blk = 5'h00;
	logic [19:0] pa = 20'hfffff;
	logic [15:0] pd = 16'hffff;
	logic [15:0] rd;
	logic [15:0] last = 16'h0000;
	logic [7:0] d;
	assign d = dq_in[7:0];

	function automatic logic at(input logic [10:0] w, input logic l);
		return addr_in[10:0] == w && (byte_n_in || dq_in[15] == l);
	endfunction

	always @(posedge we_n_in or posedge op_end_in) begin
		if (op_end_in) begin
			// Busy operation finished
			if (mode == MD_BUSY_PROG || mode == MD_BUSY_CHIP || mode == MD_BUSY_BLK) begin
				mode <= byp ? MD_BYPASS : MD_ARRAY;
			end
		end else if (!ce_n_in) begin
			step <= 4'h0;
			rst_ok <= 1'b0;
			if (mode == MD_BUSY_BLK) begin
				if (d == 8'hb0) begin
					susp <= 1'b1;
					mode <= MD_ARRAY;
				end else if (d == 8'h30 && list_open) begin
					blk <= addr_in[19:15];
				end
			end else if (mode == MD_BUSY_PROG || mode == MD_BUSY_CHIP) begin
				step <= 4'h0;
			end else if (step == 4'h3) begin
				if (!(susp && addr_in[19:15] == blk)) begin
					pa <= addr_in;
					pd <= dq_in;
					mode <= MD_BUSY_PROG;
				end
			end else if (mode == MD_BYPASS) begin
				if (d == 8'ha0) step <= 4'h3;
				else if (d == 8'h90) step <= 4'h7;
				else if (step == 4'h7 && d == 8'h00) begin
					mode <= MD_ARRAY;
					byp <= 1'b0;
				end
			end else if (d == 8'hf0) begin
				mode <= (mode == MD_QRY_IDENT) ? MD_IDENT : MD_ARRAY;
				rst_ok <= (mode == MD_ARRAY || mode == MD_QRY_ARR);
			end else if (d == 8'h98 && at(11'h055, 1'b0)) begin
				if (mode == MD_ARRAY) mode <= MD_QRY_ARR;
				else if (mode == MD_IDENT) mode <= MD_QRY_IDENT;
			end else if (mode == MD_ARRAY && d == 8'h30 && susp && rst_ok) begin
				susp <= 1'b0;
				list_open <= 1'b0;
				mode <= MD_BUSY_BLK;
			end else if (mode == MD_ARRAY) begin
				case (step)
					4'h0, 4'h4: if (d == 8'haa && at(11'h555, 1'b0)) step <= step + 4'h1;
					4'h1, 4'h5: if (d == 8'h55 && at(11'h2aa, 1'b1)) step <= step + 4'h1;
					4'h2: if (at(11'h555, 1'b0)) begin
						if (d == 8'h90) mode <= MD_IDENT;
						else if (d == 8'ha0) step <= 4'h3;
						else if (d == 8'h80 && !susp) step <= 4'h4;
						else if (d == 8'h20) begin
							mode <= MD_BYPASS;
							byp <= 1'b1;
						end
					end
					4'h6: if (d == 8'h10 && at(11'h555, 1'b0)) mode <= MD_BUSY_CHIP;
					else if (d == 8'h30) begin
						blk <= addr_in[19:15];
						list_open <= 1'b1;
						mode <= MD_BUSY_BLK;
					end
					default: step <= 4'h0;
				endcase
			end
		end
	end

	always_comb begin
		if (mode == MD_QRY_ARR || mode == MD_QRY_IDENT) rd = 16'h0051;
		else if (mode == MD_IDENT) rd = ID_CODE;
		else if (mode == MD_BUSY_PROG || mode == MD_BUSY_CHIP || mode == MD_BUSY_BLK) rd = 16'h0000;
		else if (susp && addr_in[19:15] == blk) rd = 16'h0080;
		else rd = (addr_in == pa) ? pd : 16'hffff;
	end

	always @(posedge oe_n_in) last <= rd;
	// Released bus shows inverted last read
	assign dq_out = (!ce_n_in && !oe_n_in) ? rd : ~last;
endmodule

// file: testbench/testbench.sv
module testbench;
	import fcsr_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic req_valid_in = 1'b0;
	logic byte_mode_in = 1'b0;
	logic op_end_in = 1'b0;
	logic en_in = 1'b1;
	fcsr_req_s req_in = '0;
	logic ready_out, done_out, err_out, suspended_out, dq_oe_out;
	logic ce_n_out, we_n_out, oe_n_out, byte_n_out;
	logic [15:0] rdata_out, dq_out, dev_dq, dq_w;
	logic [19:0] addr_out;
	fcsr_mode_e mode_out;
	int fail_count = 0;
	int cmp_count = 0;
	int cyc = 0;

	always #25 clk_in = ~clk_in;
	assign dq_w = dq_oe_out ? dq_out : dev_dq;

	fcsr_host dut_u (.clk_in(clk_in), .arst_n_in(arst_n_in), .en_in(en_in),
		.req_valid_in(req_valid_in), .req_in(req_in), .byte_mode_in(byte_mode_in),
		.op_end_in(op_end_in), .dq_in(dq_w), .ready_out(ready_out), .done_out(done_out),
		.err_out(err_out), .rdata_out(rdata_out), .suspended_out(suspended_out),
		.mode_out(mode_out), .addr_out(addr_out), .dq_out(dq_out), .dq_oe_out(dq_oe_out),
		.ce_n_out(ce_n_out), .we_n_out(we_n_out), .oe_n_out(oe_n_out), .byte_n_out(byte_n_out));

	fcsr_flash_model flash_u (.ce_n_in(ce_n_out), .we_n_in(we_n_out), .oe_n_in(oe_n_out),
		.byte_n_in(byte_n_out), .op_end_in(op_end_in), .addr_in(addr_out), .dq_in(dq_w),
		.dq_out(dev_dq));

	task automatic final_report;
		$display("mismatches %0d, compares %0d", fail_count, cmp_count);
		if (fail_count == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			$display("BAD %0t timeout", $time);
			final_report();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic chk_mode(input fcsr_mode_e exp);
		cmp_count++;
		if (mode_out !== exp || flash_u.mode !== exp) begin
			fail_count++;
			$display("BAD %0t mode host %0d flash %0d expected %0d", $time, mode_out,
				flash_u.mode, exp);
		end
	endtask

	task automatic req(input fcsr_op_e op, input logic [19:0] a, input logic [15:0] d,
		input logic ok);
		int n;
		n = 0;
		while (ready_out !== 1'b1 && n < 100) begin
			@(posedge clk_in);
			#1;
			n++;
		end
		req_in = '{op: op, addr: a, alsb: 1'b0, data: d};
		req_valid_in = 1'b1;
		@(posedge clk_in);
		#1;
		req_valid_in = 1'b0;
		n = 0;
		while (done_out !== 1'b1 && err_out !== 1'b1 && n < 2000) begin
			@(posedge clk_in);
			#1;
			n++;
		end
		chk({14'h0, done_out, err_out}, {14'h0, ok, !ok}, "request outcome");
		@(posedge clk_in);
		#1;
	endtask

	task automatic rd(input logic [19:0] a, input logic [15:0] m, input logic [15:0] exp);
		req(OP_READ, a, 16'h0000, 1'b1);
		chk(rdata_out & m, exp, "read data");
	endtask

	task automatic end_op;
		op_end_in = 1'b1;
		@(posedge clk_in);
		#1;
		op_end_in = 1'b0;
		@(posedge clk_in);
		#1;
	endtask

	task automatic t_program;
		req(OP_PROG, 20'h01234, 16'hbeef, 1'b1);
		chk_mode(MD_BUSY_PROG);
		chk(flash_u.pd, 16'hbeef, "programmed value");
		req(OP_RESET, 20'h0, 16'h0, 1'b0);
		end_op();
		chk_mode(MD_ARRAY);
		rd(20'h01234, 16'hffff, 16'hbeef);
	endtask

	task automatic t_suspend;
		req(OP_BLK_ERASE, 20'h18000, 16'h0, 1'b1);
		chk_mode(MD_BUSY_BLK);
		req(OP_RESET, 20'h0, 16'h0, 1'b0);
		req(OP_SUSPEND, 20'h0, 16'h0, 1'b1);
		chk({15'h0, suspended_out}, 16'h0001, "suspended flag");
		chk_mode(MD_ARRAY);
		rd(20'h18004, 16'h0080, 16'h0080);
		rd(20'h01234, 16'hffff, 16'hbeef);
		req(OP_PROG, 20'h18010, 16'h1111, 1'b0);
		chk(flash_u.pd, 16'hbeef, "discarded program");
		req(OP_PROG, 20'h02000, 16'h2222, 1'b1);
		end_op();
		rd(20'h02000, 16'hffff, 16'h2222);
		req(OP_RESUME, 20'h0, 16'h0, 1'b0);
		req(OP_AUTOSEL, 20'h0, 16'h0, 1'b1);
		chk_mode(MD_IDENT);
		req(OP_RESET, 20'h0, 16'h0, 1'b1);
		req(OP_RESET, 20'h0, 16'h0, 1'b1);
		req(OP_RESUME, 20'h0, 16'h0, 1'b1);
		chk_mode(MD_BUSY_BLK);
		req(OP_BLK_ADD, 20'h20000, 16'h0, 1'b0);
		req(OP_SUSPEND, 20'h0, 16'h0, 1'b1);
		req(OP_RESET, 20'h0, 16'h0, 1'b1);
		req(OP_RESUME, 20'h0, 16'h0, 1'b1);
		chk({15'h0, suspended_out}, 16'h0000, "resumed flag");
		end_op();
		chk_mode(MD_ARRAY);
	endtask

	task automatic t_query;
		req(OP_QUERY, 20'h00055, 16'h0, 1'b1);
		chk_mode(MD_QRY_ARR);
		rd(20'h00010, 16'hffff, 16'h0051);
		req(OP_RESET, 20'h0, 16'h0, 1'b1);
		chk_mode(MD_ARRAY);
		req(OP_AUTOSEL, 20'h0, 16'h0, 1'b1);
		rd(20'h00000, 16'hffff, 16'h1a2b);
		req(OP_QUERY, 20'h00055, 16'h0, 1'b1);
		chk_mode(MD_QRY_IDENT);
		req(OP_RESET, 20'h0, 16'h0, 1'b1);
		chk_mode(MD_IDENT);
		req(OP_RESET, 20'h0, 16'h0, 1'b1);
		chk_mode(MD_ARRAY);
		byte_mode_in = 1'b1;
		req(OP_AUTOSEL, 20'h0, 16'h0, 1'b1);
		chk_mode(MD_IDENT);
		req(OP_RESET, 20'h0, 16'h0, 1'b1);
		req(OP_QUERY, 20'h00055, 16'h0, 1'b1);
		chk_mode(MD_QRY_ARR);
		req(OP_RESET, 20'h0, 16'h0, 1'b1);
		byte_mode_in = 1'b0;
	endtask

	task automatic t_bypass;
		req(OP_BYP_ENTER, 20'h0, 16'h0, 1'b1);
		chk_mode(MD_BYPASS);
		req(OP_QUERY, 20'h00055, 16'h0, 1'b0);
		req(OP_BYP_PROG, 20'h03000, 16'h3333, 1'b1);
		chk(flash_u.pd, 16'h3333, "bypass value");
		end_op();
		chk_mode(MD_BYPASS);
		req(OP_BYP_EXIT, 20'h0, 16'h0, 1'b1);
		chk_mode(MD_ARRAY);
		rd(20'h03000, 16'hffff, 16'h3333);
	endtask

	task automatic t_chip;
		req(OP_CHIP_ERASE, 20'h0, 16'h0, 1'b1);
		chk_mode(MD_BUSY_CHIP);
		req(OP_SUSPEND, 20'h0, 16'h0, 1'b0);
		end_op();
		chk_mode(MD_ARRAY);
	endtask

	// Clock enable low: a pending request must not be taken
	task automatic t_freeze;
		en_in = 1'b0;
		req_in = '{op: OP_READ, addr: 20'h0, alsb: 1'b0, data: 16'h0};
		req_valid_in = 1'b1;
		repeat (3) @(posedge clk_in);
		#1;
		chk({12'h0, ready_out, done_out, err_out, oe_n_out}, 16'h0009, "frozen state");
		chk_mode(MD_ARRAY);
		req_valid_in = 1'b0;
		en_in = 1'b1;
	endtask

	initial begin
		repeat (3) @(posedge clk_in);
		#1;
		arst_n_in = 1'b1;
		chk({14'h0, ready_out, suspended_out}, 16'h0002, "reset state");
		chk_mode(MD_ARRAY);
		t_program();
		t_suspend();
		t_query();
		t_bypass();
		t_chip();
		t_freeze();
		final_report();
	end
endmodule
